// >>> core/adtr_ctrl.sv
// Converter control: trigger select, result register and power-fail compare
`timescale 1ns/1ps
`include "adtr_defs.svh"
module adtr_ctrl #(
    parameter int RES_BITS = 10
) (
    input  wire logic                   clock,
    input  wire logic                   nrst,
    input  wire adtr_pkg::adtr_bus_req_t busReq,
    output logic [15:0]                 busRdata,
    output logic                        busWait,
    input  wire logic                   swStart,
    input  wire logic                   scanModeBit,
    input  wire logic [7:0]             thresholdValue,
    input  wire logic                   extTriggerPin,
    input  wire logic                   timerTriggerReq,
    input  wire logic                   convEnd,
    input  wire logic [RES_BITS-1:0]    approximationReg,
    output logic                        convStart,
    output logic                        convAbort,
    output logic [1:0]                  analogSel,
    output logic                        scanActive,
    output logic [2:0]                  scanLast,
    output logic                        conversionDoneIrq
);
    adtr_pkg::adtr_chsel_t  chsel_r;
    adtr_pkg::adtr_pfmode_t pfmode_r;
    logic [15:0]            result_r;
    logic                   wait_r;
    logic                   busy_r;
    logic [1:0]             chan_r;
    logic [1:0]             chan_nxt;
    logic                   pinPulse;
    logic                   hwStart;
    logic                   irqAllow;
    logic                   wrChsel;
    logic                   wrPfmode;
    logic                   rdResult;
    adtr_pkg::adtr_edge_t   edgeQual;
    logic [7:0]             resHiNow;

    // Byte or single-bit merge of a write
    function automatic logic [7:0] merge_wr(input logic [7:0] cur, input adtr_pkg::adtr_bus_req_t r);
        logic [7:0] v;
        v = cur;
        if (r.bitOp) begin
            v[r.bitIdx] = r.wdata[0];
        end else begin
            v = r.wdata;
        end
        return v;
    endfunction

    // Address decode
    assign wrChsel  = busReq.wr && busReq.addr == `ADTR_ADDR_CHSEL;
    assign wrPfmode = busReq.wr && busReq.addr == `ADTR_ADDR_PFMODE;
    assign rdResult = busReq.rd && !busReq.bitOp && busReq.addr == `ADTR_ADDR_RESULT_LO;

    // Channel-select register
    always_ff @(posedge clock) begin
        if (!nrst) begin
            chsel_r <= `ADTR_CHSEL_RESET;
        end else if (wrChsel) begin
            chsel_r <= merge_wr(chsel_r, busReq);
        end
    end

    // Compare mode register, low six bits held zero
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pfmode_r <= `ADTR_PFMODE_RESET;
        end else if (wrPfmode) begin
            pfmode_r <= merge_wr(pfmode_r, busReq) & `ADTR_PFMODE_MASK;
        end
    end

    // One wait cycle on channel-select write and result read
    always_ff @(posedge clock) begin
        if (!nrst) begin
            wait_r <= 1'b0;
        end else begin
            wait_r <= (wrChsel || rdResult) && !wait_r;
        end
    end
    assign busWait = (wrChsel || rdResult) && !wait_r;

    // Read data, result as one 16-bit word
    always_ff @(posedge clock) begin
        if (!nrst) begin
            busRdata <= 16'h0000;
        end else if (busReq.rd) begin
            case (busReq.addr)
                `ADTR_ADDR_RESULT_LO: busRdata <= result_r;
                `ADTR_ADDR_CHSEL:     busRdata <= {8'h00, chsel_r};
                `ADTR_ADDR_PFMODE:    busRdata <= {8'h00, pfmode_r};
                default:              busRdata <= 16'h0000;
            endcase
        end
    end

    // Edge field qualified only by hardware pin trigger
    assign edgeQual = (chsel_r.hwTrig && !chsel_r.kind) ? chsel_r.trigEdge : adtr_pkg::EDGE_NONE;

    adtr_edge_det u_edge (
        .clock     (clock),
        .nrst      (nrst),
        .pinIn     (extTriggerPin),
        .edgeSel   (edgeQual),
        .trigPulse (pinPulse)
    );

    // Trigger source select
    always_comb begin
        if (!chsel_r.hwTrig) begin
            hwStart = 1'b0;
        end else if (chsel_r.kind) begin
            hwStart = timerTriggerReq;
        end else begin
            hwStart = pinPulse && !busy_r;
        end
    end
    assign convStart = chsel_r.hwTrig ? hwStart : swStart;
    assign convAbort = busy_r && (wrChsel || wrPfmode || (chsel_r.hwTrig && chsel_r.kind && timerTriggerReq));

    // Conversion busy tracking
    always_ff @(posedge clock) begin
        if (!nrst) begin
            busy_r <= 1'b0;
        end else if (convStart) begin
            busy_r <= 1'b1;
        end else if (convEnd || wrChsel || wrPfmode) begin
            busy_r <= 1'b0;
        end
    end

    // Select or scan channel stepping
    assign scanActive = scanModeBit;
    assign scanLast   = chsel_r.chan;
    assign analogSel  = scanModeBit ? chan_r : chsel_r.chan[1:0];
    always_comb begin
        chan_nxt = chan_r;
        if (wrChsel) begin
            chan_nxt = 2'b00;
        end else if (convEnd && scanModeBit) begin
            chan_nxt = (chan_r >= chsel_r.chan[1:0]) ? 2'b00 : chan_r + 2'b01;
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst) begin
            chan_r <= 2'b00;
        end else begin
            chan_r <= chan_nxt;
        end
    end

    // Result load, left aligned, no reset value
    always_ff @(posedge clock) begin
        if (convEnd) begin
            result_r <= {approximationReg, {`ADTR_RESULT_PAD{1'b0}}};
        end
    end

    assign resHiNow = approximationReg[RES_BITS-1 -: 8];

    adtr_compare u_cmp (
        .cmpEn     (pfmode_r.en),
        .cmpPol    (pfmode_r.pol),
        .resultHi  (resHiNow),
        .threshold (thresholdValue),
        .irqAllow  (irqAllow)
    );

    // Conversion-end interrupt pulse
    always_ff @(posedge clock) begin
        if (!nrst) begin
            conversionDoneIrq <= 1'b0;
        end else begin
            conversionDoneIrq <= convEnd && irqAllow;
        end
    end

    sequence s_end_seen;
        convEnd && !pfmode_r.en;
    endsequence
    property p_irq_nocmp;
        @(posedge clock) disable iff (!nrst) s_end_seen |=> conversionDoneIrq;
    endproperty
    a_irq_nocmp: assert property (p_irq_nocmp) else $error("irq missing with compare off");

    property p_irq_pol0;
        @(posedge clock) disable iff (!nrst)
        (convEnd && pfmode_r.en && !pfmode_r.pol && resHiNow < thresholdValue) |=> !conversionDoneIrq;
    endproperty
    a_irq_pol0: assert property (p_irq_pol0) else $error("irq below threshold with polarity 0");

    property p_irq_pol1;
        @(posedge clock) disable iff (!nrst)
        (convEnd && pfmode_r.en && pfmode_r.pol && resHiNow < thresholdValue) |=> conversionDoneIrq;
    endproperty
    a_irq_pol1: assert property (p_irq_pol1) else $error("irq missing below threshold");

    property p_result_load;
        @(posedge clock) disable iff (!nrst)
        convEnd |=> result_r[15:6] == $past(approximationReg) && result_r[5:0] == 6'h00;
    endproperty
    a_result_load: assert property (p_result_load) else $error("result not loaded aligned");

    property p_pfm_low;
        @(posedge clock) disable iff (!nrst) pfmode_r.rsvd == 6'h00;
    endproperty
    a_pfm_low: assert property (p_pfm_low) else $error("compare mode low bits set");

    property p_wait_chsel;
        @(posedge clock) disable iff (!nrst) (wrChsel && !wait_r) |-> busWait ##1 wait_r;
    endproperty
    a_wait_chsel: assert property (p_wait_chsel) else $error("no wait on channel write");

    property p_wait_read;
        @(posedge clock) disable iff (!nrst) (rdResult && !wait_r) |-> busWait;
    endproperty
    a_wait_read: assert property (p_wait_read) else $error("no wait on result read");

    property p_sw_no_hw;
        @(posedge clock) disable iff (!nrst) !chsel_r.hwTrig |-> convStart == swStart;
    endproperty
    a_sw_no_hw: assert property (p_sw_no_hw) else $error("hardware trigger in software mode");

    property p_chsel_reset;
        @(posedge clock) !nrst |=> chsel_r == 8'h00;
    endproperty
    a_chsel_reset: assert property (p_chsel_reset) else $error("channel select not reset");

    // Trigger source checks
    property p_timer_start;
        @(posedge clock) disable iff (!nrst)
        (chsel_r.hwTrig && chsel_r.kind && timerTriggerReq) |-> convStart;
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer request did not start");

    property p_pin_start;
        @(posedge clock) disable iff (!nrst)
        (chsel_r.hwTrig && !chsel_r.kind && pinPulse && !busy_r) |-> convStart;
    endproperty
    a_pin_start: assert property (p_pin_start) else $error("pin edge did not start");

    property p_pin_busy;
        @(posedge clock) disable iff (!nrst)
        (chsel_r.hwTrig && !chsel_r.kind && busy_r) |-> !convStart;
    endproperty
    a_pin_busy: assert property (p_pin_busy) else $error("pin edge restarted a conversion");

    property p_edge_gate;
        @(posedge clock) disable iff (!nrst)
        (!chsel_r.hwTrig || chsel_r.kind) |-> !pinPulse;
    endproperty
    a_edge_gate: assert property (p_edge_gate) else $error("edge setting used outside pin trigger");

    property p_kind_ignored;
        @(posedge clock) disable iff (!nrst)
        (!chsel_r.hwTrig && timerTriggerReq && !swStart) |-> !convStart;
    endproperty
    a_kind_ignored: assert property (p_kind_ignored) else $error("timer request in software mode");

    // Scan stepping checks
    sequence s_scan_wrap;
        convEnd && scanModeBit && !wrChsel && chan_r == chsel_r.chan[1:0];
    endsequence
    sequence s_scan_step;
        convEnd && scanModeBit && !wrChsel && chan_r < chsel_r.chan[1:0];
    endsequence

    property p_scan_wrap;
        @(posedge clock) disable iff (!nrst) s_scan_wrap |=> chan_r == 2'b00;
    endproperty
    a_scan_wrap: assert property (p_scan_wrap) else $error("scan did not wrap to input 0");

    property p_scan_step;
        @(posedge clock) disable iff (!nrst) s_scan_step |=> chan_r == $past(chan_r) + 2'b01;
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan did not step to next input");

    property p_chwr_first;
        @(posedge clock) disable iff (!nrst) wrChsel |=> chan_r == 2'b00;
    endproperty
    a_chwr_first: assert property (p_chwr_first) else $error("scan did not restart at input 0");

    property p_select_input;
        @(posedge clock) disable iff (!nrst) !scanModeBit |-> analogSel == chsel_r.chan[1:0];
    endproperty
    a_select_input: assert property (p_select_input) else $error("select mode input wrong");

    property p_scan_input;
        @(posedge clock) disable iff (!nrst) scanModeBit |-> analogSel == chan_r && scanActive;
    endproperty
    a_scan_input: assert property (p_scan_input) else $error("scan mode input wrong");

    // Register hold and read word checks
    property p_chsel_hold;
        @(posedge clock) disable iff (!nrst) !wrChsel |=> $stable(chsel_r);
    endproperty
    a_chsel_hold: assert property (p_chsel_hold) else $error("channel select changed without write");

    property p_pfm_hold;
        @(posedge clock) disable iff (!nrst) !wrPfmode |=> $stable(pfmode_r);
    endproperty
    a_pfm_hold: assert property (p_pfm_hold) else $error("compare mode changed without write");

    property p_rd_word;
        @(posedge clock) disable iff (!nrst) (rdResult && !wait_r) |=> busRdata == $past(result_r);
    endproperty
    a_rd_word: assert property (p_rd_word) else $error("result word not returned");
endmodule

// >>> core/adtr_defs.svh
// Offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADTR_DEFS_SVH
`define ADTR_DEFS_SVH
`define ADTR_ADDR_RESULT_LO 16'hff1a
`define ADTR_ADDR_RESULT_HI 16'hff1b
`define ADTR_ADDR_CHSEL     16'hff6d
`define ADTR_ADDR_PFMODE    16'hff6e
`define ADTR_CHSEL_RESET    8'h00
`define ADTR_PFMODE_RESET   8'h00
`define ADTR_PFMODE_MASK    8'hc0
`define ADTR_BIT_EDGE_HI    7
`define ADTR_BIT_EDGE_LO    6
`define ADTR_BIT_HWTRIG     5
`define ADTR_BIT_KIND       4
`define ADTR_BIT_CMP_EN     7
`define ADTR_BIT_CMP_POL    6
`define ADTR_RESULT_PAD     6
`define ADTR_WAIT_CYCLES    1
`endif

// >>> core/adtr_pkg.sv
// Types shared by the converter control block
package adtr_pkg;
    typedef enum logic [1:0] {
        EDGE_NONE,
        EDGE_FALL,
        EDGE_RISE,
        EDGE_BOTH
    } adtr_edge_t;

    typedef struct packed {
        adtr_edge_t trigEdge;
        logic       hwTrig;
        logic       kind;
        logic       rsvd3;
        logic [2:0] chan;
    } adtr_chsel_t;

    typedef struct packed {
        logic       en;
        logic       pol;
        logic [5:0] rsvd;
    } adtr_pfmode_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        bitOp;
        logic [2:0]  bitIdx;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } adtr_bus_req_t;
endpackage

// >>> core/adtr_edge_det.sv
// Synchronous edge detector for the external trigger pin
`timescale 1ns/1ps
module adtr_edge_det (
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic               pinIn,
    input  wire adtr_pkg::adtr_edge_t edgeSel,
    output logic                    trigPulse
);
    logic pinPrev_r;
    logic pinCur_r;

    // Pin sampled on the system clock
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pinCur_r  <= 1'b0;
            pinPrev_r <= 1'b0;
        end else begin
            pinCur_r  <= pinIn;
            pinPrev_r <= pinCur_r;
        end
    end

    // One pulse per qualifying edge
    always_comb begin
        case (edgeSel)
            adtr_pkg::EDGE_FALL: trigPulse = pinPrev_r & ~pinCur_r;
            adtr_pkg::EDGE_RISE: trigPulse = ~pinPrev_r & pinCur_r;
            adtr_pkg::EDGE_BOTH: trigPulse = pinPrev_r ^ pinCur_r;
            default:             trigPulse = 1'b0;
        endcase
    end

    property p_fall_pulse;
        @(posedge clock) disable iff (!nrst)
        (edgeSel == adtr_pkg::EDGE_FALL && pinPrev_r && !pinCur_r) |-> trigPulse;
    endproperty
    a_fall_pulse: assert property (p_fall_pulse) else $error("falling edge missed");

    property p_single_pulse;
        @(posedge clock) disable iff (!nrst)
        (trigPulse && edgeSel != adtr_pkg::EDGE_BOTH) |=> !trigPulse;
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("trigger pulse too long");
endmodule

// >>> core/adtr_compare.sv
// Threshold comparison that gates the conversion-end interrupt
`timescale 1ns/1ps
module adtr_compare (
    input  wire logic       cmpEn,
    input  wire logic       cmpPol,
    input  wire logic [7:0] resultHi,
    input  wire logic [7:0] threshold,
    output logic            irqAllow
);
    logic atOrAbove;

    // Upper result byte against threshold
    assign atOrAbove = (resultHi >= threshold);
    // Disabled compare always allows, else polarity picks
    assign irqAllow  = !cmpEn ? 1'b1 : (cmpPol ? !atOrAbove : atOrAbove);
endmodule

// >>> test/adtr_seq_model.sv
// Behavioural conversion sequencer at the far side of the control block
`timescale 1ns/1ps
module adtr_seq_model #(
    parameter int LAT = 4
) (
    input  wire logic       clock,
    input  wire logic       nrst,
    input  wire logic       convStart,
    input  wire logic       convAbort,
    input  wire logic [9:0] value,
    output logic            convEnd,
    output logic [9:0]      approximationReg
);
    int cnt;

    // Down counter from a start; a restart wins over an abort
    always_ff @(posedge clock) begin
        if (!nrst) cnt <= 0;
        else if (convStart) cnt <= LAT;
        else if (convAbort) cnt <= 0;
        else if (cnt > 0) cnt <= cnt - 1;
    end

    // End pulse; result shown only in that cycle, inverse otherwise
    assign convEnd          = (cnt == 1);
    assign approximationReg = convEnd ? value : ~value;
endmodule

// >>> test/tb_adc_trigger_result_powerfail.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_adc_trigger_result_powerfail;
    logic                   clock, nrst, swStart, scanModeBit, extTriggerPin, timerTriggerReq;
    logic                   convEnd, convStart, convAbort, scanActive, conversionDoneIrq, busWait, w;
    logic [7:0]             thresholdValue;
    logic [9:0]             approximationReg, convValue;
    logic [15:0]            busRdata, q;
    logic [1:0]             analogSel;
    logic [2:0]             scanLast;
    adtr_pkg::adtr_bus_req_t busReq;
    int                     n_fail = 0, checked = 0, nStart = 0, nIrq = 0, nAbort = 0, nEnd = 0;

    adtr_ctrl DUT (.clock(clock), .nrst(nrst), .busReq(busReq), .busRdata(busRdata), .busWait(busWait),
        .swStart(swStart), .scanModeBit(scanModeBit), .thresholdValue(thresholdValue),
        .extTriggerPin(extTriggerPin), .timerTriggerReq(timerTriggerReq), .convEnd(convEnd),
        .approximationReg(approximationReg), .convStart(convStart), .convAbort(convAbort),
        .analogSel(analogSel), .scanActive(scanActive), .scanLast(scanLast),
        .conversionDoneIrq(conversionDoneIrq));
    adtr_seq_model SEQ (.clock(clock), .nrst(nrst), .convStart(convStart), .convAbort(convAbort),
        .value(convValue), .convEnd(convEnd), .approximationReg(approximationReg));

    // Clock at 25 ns
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Start, interrupt, abort and end pulses seen
    always @(posedge clock) begin
        if (convStart === 1'b1) nStart++;
        if (conversionDoneIrq === 1'b1) nIrq++;
        if (convAbort === 1'b1) nAbort++;
        if (convEnd === 1'b1) nEnd++;
    end

    // One bus access, held through the wait cycle
    task bus(input logic rd, input logic wr, input logic bo, input logic [2:0] idx,
             input logic [15:0] a, input logic [7:0] d);
        @(negedge clock);
        busReq = '{rd, wr, bo, idx, a, d};
        #1 w = busWait;
        repeat (w === 1'b1 ? 2 : 1) @(posedge clock);
        @(negedge clock);
        q = busRdata;
        busReq = '0;
    endtask

    task t_regs;
        bus(1, 0, 0, 0, 16'hff6d, 0);
        `CHK("chsel reset", 8'h00, q[7:0])
        bus(1, 0, 0, 0, 16'hff6e, 0);
        `CHK("pfmode reset", 8'h00, q[7:0])
        bus(1, 0, 0, 0, 16'h1234, 0);
        `CHK("unmapped read", 16'h0000, q)
        bus(0, 1, 0, 0, 16'hff6d, 8'hf3);
        `CHK("chsel write wait", 1'b1, w)
        bus(0, 1, 1, 3'h5, 16'hff6d, 8'h00);
        bus(1, 0, 0, 0, 16'hff6d, 0);
        `CHK("chsel bit write", 8'hd3, q[7:0])
        bus(0, 1, 0, 0, 16'hff6e, 8'hff);
        bus(1, 0, 0, 0, 16'hff6e, 0);
        `CHK("pfmode fixed bits", 8'hc0, q[7:0])
        bus(0, 1, 1, 3'h7, 16'hff6e, 8'h00);
        bus(1, 0, 0, 0, 16'hff6e, 0);
        `CHK("pfmode bit write", 8'h40, q[7:0])
        bus(0, 1, 0, 0, 16'hff6d, 8'h00);
        $display("test regs done");
    endtask

    // Software conversion, irq count, then word read before the next write
    task conv(input logic [9:0] v, input logic en, input logic pol, input logic [7:0] thr, input int irq);
        int n0;
        bus(0, 1, 0, 0, 16'hff6e, {en, pol, 6'h00});
        thresholdValue = thr;
        convValue = v;
        n0 = nIrq;
        swStart = 1'b1;
        @(negedge clock);
        swStart = 1'b0;
        for (int i = 0; i < 20 && convEnd !== 1'b1; i++) @(negedge clock);
        `CHK("conversion end", 1'b1, convEnd)
        repeat (3) @(negedge clock);
        `CHK("irq count", irq, nIrq - n0)
        bus(1, 0, 0, 0, 16'hff1a, 0);
        `CHK("result read wait", 1'b1, w)
        `CHK("result word", {v, 6'h00}, q)
        `CHK("result high byte", v[9:2], q[15:8])
    endtask

    // Trigger setting, pin toggles and timer pulse against start count
    task trig(input logic [7:0] cs, input int edges, input logic tmr, input int exp);
        int n0;
        extTriggerPin = 1'b0;
        bus(0, 1, 0, 0, 16'hff6d, cs);
        repeat (3) @(negedge clock);
        n0 = nStart;
        for (int i = 0; i < edges; i++) begin
            extTriggerPin = ~extTriggerPin;
            repeat (10) @(negedge clock);
        end
        if (tmr) begin
            timerTriggerReq = 1'b1;
            @(negedge clock);
            timerTriggerReq = 1'b0;
        end
        repeat (10) @(negedge clock);
        `CHK("start count", exp, nStart - n0)
    endtask

    // Select input, scan stepping over code 2, then a write that aborts a conversion
    task t_scan;
        int n0, e0;
        bus(0, 1, 0, 0, 16'hff6d, 8'h02);
        @(negedge clock);
        `CHK("select input", 2'h2, analogSel)
        scanModeBit = 1'b1;
        @(negedge clock);
        `CHK("scan active", 1'b1, scanActive)
        `CHK("scan last", 3'h2, scanLast)
        for (int k = 0; k < 4; k++) begin
            `CHK("scan input", k % 3, analogSel)
            swStart = 1'b1;
            @(negedge clock);
            swStart = 1'b0;
            for (int i = 0; i < 20 && convEnd !== 1'b1; i++) @(negedge clock);
            @(negedge clock);
        end
        n0 = nAbort;
        e0 = nEnd;
        swStart = 1'b1;
        @(negedge clock);
        swStart = 1'b0;
        bus(0, 1, 0, 0, 16'hff6d, 8'h00);
        repeat (10) @(negedge clock);
        `CHK("abort count", 1, nAbort - n0)
        `CHK("end after abort", 0, nEnd - e0)
        scanModeBit = 1'b0;
        $display("test scan done");
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard, well past the expected run
    initial begin
        #150000;
        n_fail++;
        stop_test;
    end

    initial begin
        nrst = 1'b0;
        swStart = 1'b0;
        scanModeBit = 1'b0;
        extTriggerPin = 1'b0;
        timerTriggerReq = 1'b0;
        thresholdValue = 8'h00;
        convValue = 10'h000;
        busReq = '0;
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        t_regs;
        conv(10'h004, 0, 0, 8'hff, 1);
        conv(10'h200, 1, 0, 8'h80, 1);
        conv(10'h1fc, 1, 0, 8'h80, 0);
        conv(10'h1fc, 1, 1, 8'h80, 1);
        conv(10'h200, 1, 1, 8'h80, 0);
        $display("test compare done");
        trig(8'h20, 2, 0, 0);
        trig(8'h60, 2, 0, 1);
        trig(8'ha0, 2, 0, 1);
        trig(8'he0, 2, 0, 2);
        trig(8'hf0, 2, 1, 1);
        trig(8'hc0, 2, 0, 0);
        trig(8'h10, 0, 1, 0);
        $display("test trigger done");
        t_scan;
        stop_test;
    end
endmodule
